// >>> rtl/cpubi_pkg.sv
// Constants, states and cycle kinds for the system bus interface.
// Assumes a single 10 MHz processor clock shared by the whole block.
package cpubi_pkg;
  localparam int ADDR_W = 20; // Address bus width
  localparam int DATA_W = 8; // Data bus width
  localparam int REFRESH_W = 8; // Refresh address width, low bits
  localparam int TMR_BIT = 18; // Address bit shared with timer output
  localparam logic [7:0] REFRESH_RST = 8'h00; // Refresh counter after reset
  localparam logic [7:0] REFRESH_STEP = 8'h01; // Refresh counter increment

  // Machine cycle kinds requested by the core
  typedef enum logic [3:0] {
    CYC_FETCH, CYC_MEM_RD, CYC_MEM_WR, CYC_IO_RD, CYC_IO_WR,
    CYC_INTACK, CYC_REFRESH, CYC_PERIPH_RD, CYC_PERIPH_WR
  } cpubi_cyc_t;

  // Bus sequencer states
  typedef enum logic [2:0] {
    ST_IDLE, ST_T1, ST_T2, ST_TW, ST_T3, ST_FLOAT, ST_GRANT
  } cpubi_state_t;
endpackage

// >>> rtl/cpubi_bus_if.sv
// System bus interface: address, data and strobe sequencing, bus hold.
// Assumes the core issues one machine cycle at a time on the request port
// and that all pin inputs are asynchronous to clk_in.
`timescale 1ns/1ps
// Behaviour
// - Drive 20-bit address for every access
// - Refresh cycles output refresh address
// - Address floats in reset and hold, except bit 18 when timer selected
// - External master address decoded as inputs
// - Bit 18 carries timer output when selected
// - Data driven for on-chip peripheral access
// - Read strobe out, input under external master
// - Write strobe while write data valid
// - Memory strobe with valid memory address
// - Port strobe with port address low
// - Interrupt acknowledge: port and first strobes
// - Opcode fetch: first and memory strobes
// - First strobe on every opcode fetch
// - First strobe exposed for cycle decode
// - Refresh strobe together with memory strobe
// - Hold request sampled at cycle end
// - Grant only after address, data and the four strobes are floated; first and refresh strobes stay driven
// - Wait states while wait input low
module cpubi_bus_if #(
  parameter int AW = cpubi_pkg::ADDR_W, // Address width
  parameter int DW = cpubi_pkg::DATA_W // Data width
) (
  input wire logic clk_in, // Processor clock
  input wire logic rst_in, // Asynchronous reset, active high
  input wire logic req_valid_in, // Core requests a machine cycle
  output logic req_ready_out, // Sequencer can take a request
  input wire cpubi_pkg::cpubi_cyc_t req_cyc_in, // Kind of cycle
  input wire logic [AW-1:0] req_addr_in, // Access address
  input wire logic [DW-1:0] req_wdata_in, // Byte to write or present
  output logic resp_valid_out, // Cycle finished, one-cycle pulse
  output logic [DW-1:0] resp_rdata_out, // Byte read in the cycle
  input wire logic tmr_sel_in, // Pin of bit 18 carries timer output
  input wire logic timer_output_in, // Reload timer channel 1 output
  output logic [AW-1:0] addr_out, // Address pins, driven value
  output logic [AW-1:0] addr_oe_out, // Address pin enables
  input wire logic [AW-1:0] addr_in, // Address pins, sensed value
  output logic [DW-1:0] data_out, // Data pins, driven value
  output logic data_oe_out, // Data pin enable
  input wire logic [DW-1:0] data_in, // Data pins, sensed value
  output logic rd_n_out, // Read strobe, active low
  output logic wr_n_out, // Write strobe, active low
  output logic memory_cycle_n_out, // Memory cycle strobe, active low
  output logic port_cycle_n_out, // Port cycle strobe, active low
  output logic strobe_oe_out, // Enable of the four strobes above
  input wire logic rd_n_in, // Read strobe from external master
  input wire logic wr_n_in, // Write strobe from external master
  output logic first_cycle_n_out, // First cycle strobe, active low
  output logic dram_refresh_n_out, // Refresh strobe, active low
  output logic ctl_oe_out, // Enable of first and refresh strobes
  input wire logic bus_hold_request_n_in, // Hold request, active low
  output logic bus_hold_grant_n_out, // Hold grant, active low
  input wire logic wait_n_in, // Wait input, active low
  output logic periph_rd_out, // External master read, pulse
  output logic periph_wr_out, // External master write, pulse
  output logic [AW-1:0] periph_addr_out, // External master address
  output logic [DW-1:0] periph_wdata_out, // External master write byte
  input wire logic [DW-1:0] periph_rdata_in // Peripheral read byte
);
  cpubi_pkg::cpubi_state_t state_ff; // Sequencer state
  cpubi_pkg::cpubi_cyc_t cyc_ff; // Kind of cycle in progress
  logic [AW-1:0] addr_ff; // Address being driven
  logic [DW-1:0] wdata_ff; // Byte being driven
  logic [DW-1:0] rdata_ff; // Captured read byte
  logic [cpubi_pkg::REFRESH_W-1:0] refresh_ff; // Refresh row counter
  logic drive_ff; // Bus and strobes driven
  logic ctl_ff; // First and refresh strobes driven
  logic done_ff; // Cycle finished pulse
  logic [1:0] hold_sync_ff; // Hold request synchroniser
  logic [1:0] wait_sync_ff; // Wait synchroniser
  logic [1:0] rd_sync_ff; // External read synchroniser
  logic [1:0] wr_sync_ff; // External write synchroniser
  logic rd_dly_ff; // Delayed read for edge detect
  logic wr_dly_ff; // Delayed write for edge detect
  logic [AW-1:0] ain_sync1_ff; // Address input, first stage
  logic [AW-1:0] ain_sync2_ff; // Address input, second stage
  logic [DW-1:0] din_sync1_ff; // Data input, first stage
  logic [DW-1:0] din_sync2_ff; // Data input, second stage
  logic [DW-1:0] dout_ff; // Data pin value
  logic periph_rd_ff; // External read pulse
  logic periph_wr_ff; // External write pulse
  logic [AW-1:0] paddr_ff; // External master address held
  logic [DW-1:0] pwdata_ff; // External master write byte held
  cpubi_pkg::cpubi_state_t nxt_state; // Next sequencer state
  logic hold_req; // Synchronised hold request, high when asked
  logic waiting; // Synchronised wait, high when asked
  logic active; // Inside T1 to T3
  logic late; // Inside T2 to T3

  // Cycle kind decoding used by several strobes
  function automatic logic is_mem(input cpubi_pkg::cpubi_cyc_t c);
    return c == cpubi_pkg::CYC_FETCH || c == cpubi_pkg::CYC_MEM_RD ||
           c == cpubi_pkg::CYC_MEM_WR || c == cpubi_pkg::CYC_REFRESH;
  endfunction
  function automatic logic is_io(input cpubi_pkg::cpubi_cyc_t c);
    return c == cpubi_pkg::CYC_IO_RD || c == cpubi_pkg::CYC_IO_WR ||
           c == cpubi_pkg::CYC_INTACK;
  endfunction
  function automatic logic is_wr(input cpubi_pkg::cpubi_cyc_t c);
    return c == cpubi_pkg::CYC_MEM_WR || c == cpubi_pkg::CYC_IO_WR;
  endfunction
  function automatic logic is_rd(input cpubi_pkg::cpubi_cyc_t c);
    return c == cpubi_pkg::CYC_FETCH || c == cpubi_pkg::CYC_MEM_RD ||
           c == cpubi_pkg::CYC_IO_RD;
  endfunction

  assign hold_req = ~hold_sync_ff[1];
  assign waiting = ~wait_sync_ff[1];
  assign active = state_ff == cpubi_pkg::ST_T1 || late;
  assign late = state_ff == cpubi_pkg::ST_T2 ||
                state_ff == cpubi_pkg::ST_TW || state_ff == cpubi_pkg::ST_T3;

  // Two-flop synchronisers for every pin input
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      hold_sync_ff <= 2'h3;
      wait_sync_ff <= 2'h3;
      rd_sync_ff <= 2'h3;
      wr_sync_ff <= 2'h3;
      ain_sync1_ff <= '0;
      ain_sync2_ff <= '0;
      din_sync1_ff <= '0;
      din_sync2_ff <= '0;
    end else begin
      hold_sync_ff <= {hold_sync_ff[0], bus_hold_request_n_in};
      wait_sync_ff <= {wait_sync_ff[0], wait_n_in};
      rd_sync_ff <= {rd_sync_ff[0], rd_n_in};
      wr_sync_ff <= {wr_sync_ff[0], wr_n_in};
      ain_sync1_ff <= addr_in;
      ain_sync2_ff <= ain_sync1_ff;
      din_sync1_ff <= data_in;
      din_sync2_ff <= din_sync1_ff;
    end
  end

  // Next state: hold checked only between machine cycles
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      cpubi_pkg::ST_IDLE: begin
        if (hold_req) begin
          nxt_state = cpubi_pkg::ST_FLOAT;
        end else if (req_valid_in) begin
          nxt_state = cpubi_pkg::ST_T1;
        end
      end
      cpubi_pkg::ST_T1: nxt_state = cpubi_pkg::ST_T2;
      cpubi_pkg::ST_T2: begin
        // Port cycles take one wait so read data clears the synchroniser
        nxt_state = (waiting || is_io(cyc_ff)) ? cpubi_pkg::ST_TW :
                    cpubi_pkg::ST_T3;
      end
      cpubi_pkg::ST_TW: begin
        nxt_state = waiting ? cpubi_pkg::ST_TW : cpubi_pkg::ST_T3;
      end
      cpubi_pkg::ST_T3: begin
        nxt_state = hold_req ? cpubi_pkg::ST_FLOAT : cpubi_pkg::ST_IDLE;
      end
      cpubi_pkg::ST_FLOAT: nxt_state = cpubi_pkg::ST_GRANT;
      cpubi_pkg::ST_GRANT: begin
        if (!hold_req) begin
          nxt_state = cpubi_pkg::ST_IDLE;
        end
      end
    endcase
  end

  // Sequencer state and output enables
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_ff <= cpubi_pkg::ST_IDLE;
      drive_ff <= 1'b0;
      ctl_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      drive_ff <= nxt_state != cpubi_pkg::ST_FLOAT &&
                  nxt_state != cpubi_pkg::ST_GRANT;
      ctl_ff <= 1'b1;
    end
  end

  // Request capture, refresh counter and read data
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cyc_ff <= cpubi_pkg::CYC_FETCH;
      addr_ff <= '0;
      wdata_ff <= '0;
      rdata_ff <= '0;
      refresh_ff <= cpubi_pkg::REFRESH_RST;
      done_ff <= 1'b0;
    end else begin
      done_ff <= state_ff == cpubi_pkg::ST_T3;
      if (state_ff == cpubi_pkg::ST_IDLE && nxt_state == cpubi_pkg::ST_T1) begin
        cyc_ff <= req_cyc_in;
        wdata_ff <= req_wdata_in;
        if (req_cyc_in == cpubi_pkg::CYC_REFRESH) begin
          addr_ff <= {{(AW-cpubi_pkg::REFRESH_W){1'b0}}, refresh_ff};
          refresh_ff <= refresh_ff + cpubi_pkg::REFRESH_STEP;
        end else begin
          addr_ff <= req_addr_in;
        end
      end
      if (state_ff == cpubi_pkg::ST_T3) begin
        if (cyc_ff == cpubi_pkg::CYC_PERIPH_RD ||
            cyc_ff == cpubi_pkg::CYC_PERIPH_WR) begin
          rdata_ff <= wdata_ff;
        end else begin
          rdata_ff <= din_sync2_ff;
        end
      end
    end
  end

  // External master access of on-chip peripherals while granted
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_dly_ff <= 1'b1;
      wr_dly_ff <= 1'b1;
      periph_rd_ff <= 1'b0;
      periph_wr_ff <= 1'b0;
      paddr_ff <= '0;
      pwdata_ff <= '0;
    end else begin
      rd_dly_ff <= rd_sync_ff[1];
      wr_dly_ff <= wr_sync_ff[1];
      periph_rd_ff <= state_ff == cpubi_pkg::ST_GRANT &&
                      !rd_sync_ff[1] && rd_dly_ff;
      periph_wr_ff <= state_ff == cpubi_pkg::ST_GRANT &&
                      !wr_sync_ff[1] && wr_dly_ff;
      if (state_ff == cpubi_pkg::ST_GRANT) begin
        paddr_ff <= ain_sync2_ff;
      end
      if (state_ff == cpubi_pkg::ST_GRANT && !wr_sync_ff[1]) begin
        pwdata_ff <= din_sync2_ff;
      end
    end
  end

  // Data pin value: core byte, or peripheral byte for external reads
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      dout_ff <= '0;
    end else if (state_ff == cpubi_pkg::ST_GRANT) begin
      dout_ff <= periph_rdata_in;
    end else begin
      dout_ff <= wdata_ff;
    end
  end

  assign req_ready_out = state_ff == cpubi_pkg::ST_IDLE && !hold_req;
  assign resp_valid_out = done_ff;
  assign resp_rdata_out = rdata_ff;
  // Bit 18 optionally carries the timer output
  always_comb begin
    addr_out = addr_ff;
    addr_oe_out = {AW{drive_ff}};
    if (tmr_sel_in) begin
      addr_out[cpubi_pkg::TMR_BIT] = timer_output_in;
      addr_oe_out[cpubi_pkg::TMR_BIT] = 1'b1;
    end
  end
  assign data_out = dout_ff;
  assign data_oe_out = (active && drive_ff &&
                        (is_wr(cyc_ff) || cyc_ff == cpubi_pkg::CYC_PERIPH_RD ||
                         cyc_ff == cpubi_pkg::CYC_PERIPH_WR)) ||
                       (state_ff == cpubi_pkg::ST_GRANT && !rd_sync_ff[1]);
  assign memory_cycle_n_out = !(active && is_mem(cyc_ff));
  assign port_cycle_n_out = !(late && is_io(cyc_ff));
  assign rd_n_out = !(late && is_rd(cyc_ff));
  assign wr_n_out = !(late && is_wr(cyc_ff));
  assign first_cycle_n_out = !(active && (cyc_ff == cpubi_pkg::CYC_FETCH ||
                             cyc_ff == cpubi_pkg::CYC_INTACK));
  assign dram_refresh_n_out = !(active && cyc_ff == cpubi_pkg::CYC_REFRESH);
  assign strobe_oe_out = drive_ff;
  assign ctl_oe_out = ctl_ff;
  assign bus_hold_grant_n_out = state_ff != cpubi_pkg::ST_GRANT;
  assign periph_rd_out = periph_rd_ff;
  assign periph_wr_out = periph_wr_ff;
  assign periph_addr_out = paddr_ff;
  assign periph_wdata_out = pwdata_ff;

  // Checks on the bus sequencing
  a_mem_port_excl: assert property (@(posedge clk_in) disable iff (rst_in)
    !(!memory_cycle_n_out && !port_cycle_n_out))
    else $error("memory and port strobes both low");
  a_float_grant: assert property (@(posedge clk_in) disable iff (rst_in)
    !bus_hold_grant_n_out |-> !strobe_oe_out && !data_oe_out == rd_sync_ff[1])
    else $error("bus driven during grant");
  a_grant_after_float: assert property (@(posedge clk_in)
    disable iff (rst_in) $fell(bus_hold_grant_n_out) |-> $past(!strobe_oe_out))
    else $error("grant given before float");
  a_fetch_strobes: assert property (@(posedge clk_in) disable iff (rst_in)
    (!first_cycle_n_out && port_cycle_n_out && late) |-> !memory_cycle_n_out)
    else $error("fetch without memory strobe");
  a_intack_pair: assert property (@(posedge clk_in) disable iff (rst_in)
    (late && cyc_ff == cpubi_pkg::CYC_INTACK) |->
      !port_cycle_n_out && !first_cycle_n_out && memory_cycle_n_out)
    else $error("acknowledge strobes wrong");
  a_refresh_addr: assert property (@(posedge clk_in) disable iff (rst_in)
    !dram_refresh_n_out |-> !memory_cycle_n_out && rd_n_out &&
      addr_ff[AW-1:cpubi_pkg::REFRESH_W] == '0)
    else $error("refresh cycle malformed");
  a_wait_extend: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == cpubi_pkg::ST_T2 && waiting) |=> !rd_n_out || !wr_n_out ||
      !port_cycle_n_out || !memory_cycle_n_out ##0 state_ff == cpubi_pkg::ST_TW)
    else $error("wait state not inserted");
  a_hold_at_end: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == cpubi_pkg::ST_T3 && hold_req) |=> !strobe_oe_out ##1
      !bus_hold_grant_n_out)
    else $error("hold not taken at cycle end");
  a_write_data: assert property (@(posedge clk_in) disable iff (rst_in)
    !wr_n_out |-> data_oe_out && data_out == wdata_ff)
    else $error("write strobe without data");
  a_timer_mux: assert property (@(posedge clk_in) disable iff (rst_in)
    tmr_sel_in |-> addr_out[cpubi_pkg::TMR_BIT] == timer_output_in)
    else $error("timer output not on pin");
  a_ext_read: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_ff == cpubi_pkg::ST_GRANT && $fell(rd_sync_ff[1])) |=>
      periph_rd_out ##1 !periph_rd_out)
    else $error("external read not passed on");
  c_fetch: cover property (@(posedge clk_in) disable iff (rst_in)
    !first_cycle_n_out && !memory_cycle_n_out && !rd_n_out);
  c_wait: cover property (@(posedge clk_in) disable iff (rst_in)
    state_ff == cpubi_pkg::ST_TW);
  c_grant: cover property (@(posedge clk_in) disable iff (rst_in)
    !bus_hold_grant_n_out ##1 periph_wr_out);
  c_refresh: cover property (@(posedge clk_in) disable iff (rst_in)
    !dram_refresh_n_out);
endmodule // cpubi_bus_if

// >>> tb/cpubi_mem_model.sv
// Memory and port device model on the far side of the system bus.
// Assumes the bench resolves floated strobes to their pull-up level.
`timescale 1ns/1ps
module cpubi_mem_model (
  input wire logic clk_in, // Processor clock
  input wire logic rst_in, // Reset, active high
  input wire logic slow_in, // Stretch accesses with wait states
  input wire logic [19:0] addr_in, // Resolved address pins
  input wire logic mem_n_in, // Resolved memory strobe
  input wire logic ioreq_n_in, // Resolved port strobe
  input wire logic wr_n_in, // Resolved write strobe
  output logic [7:0] data_out, // Byte offered to the data pins
  output logic wait_n_out // Wait line, pulled up when released
);
  logic [2:0] stall_ff; // Cycles spent in the current access
  logic [7:0] last_ff; // Last byte driven, for the released bus
  logic sel; // Selected and not being written
  assign sel = (!mem_n_in || !ioreq_n_in) && wr_n_in;
  // Count cycles of the current access
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      stall_ff <= 3'h0;
    end else if (mem_n_in && ioreq_n_in) begin
      stall_ff <= 3'h0;
    end else if (stall_ff != 3'h7) begin
      stall_ff <= stall_ff + 3'h1;
    end
  end
  // Remember the last byte so a released bus shows its inverse
  always_ff @(posedge clk_in) begin
    if (sel) begin
      last_ff <= data_out;
    end
  end
  // Slow device pulls wait early, as the synchroniser needs two cycles
  assign wait_n_out = !(slow_in && stall_ff < 3'h3);
  // Read byte is a function of the address; vector on acknowledge
  assign data_out = sel ? (addr_in[7:0] ^ 8'ha5) : ~last_ff;
endmodule // cpubi_mem_model

// >>> tb/testbench.sv
// Self-checking bench for the system bus interface.
// Assumes the design and the memory model are compiled before it.
`timescale 1ns/1ps
module testbench;
  logic clk_in, rst_in, req_valid_in, tmr_sel_in, timer_output_in;
  cpubi_pkg::cpubi_cyc_t req_cyc_in;
  logic [19:0] req_addr_in, addr_out, addr_oe_out, addr_in;
  logic [19:0] periph_addr_out, ext_addr, seen_addr;
  logic [7:0] req_wdata_in, resp_rdata_out, data_out, data_in, mem_data;
  logic [7:0] periph_wdata_out, periph_rdata_in, ext_data, seen_data;
  logic req_ready_out, resp_valid_out, data_oe_out, rd_n_out, wr_n_out;
  logic memory_cycle_n_out, port_cycle_n_out, strobe_oe_out;
  logic first_cycle_n_out, dram_refresh_n_out, ctl_oe_out;
  logic bus_hold_grant_n_out, periph_rd_out, periph_wr_out, wait_n_in;
  logic bus_hold_request_n_in, slow, ext_rd_n, ext_wr_n, ext_den;
  logic rd_w, wr_w, mem_w, io_w; // Resolved strobe wires
  logic s_mem, s_io, s_rd, s_wr, s_first, s_rf, s_both, s_doe; // Seen flags
  int failures, total_checks, cycles, n;
  // Wire levels from every party's enables
  assign addr_in = (addr_oe_out & addr_out) | (~addr_oe_out & ext_addr);
  assign rd_w = strobe_oe_out ? rd_n_out : ext_rd_n;
  assign wr_w = strobe_oe_out ? wr_n_out : ext_wr_n;
  assign mem_w = strobe_oe_out ? memory_cycle_n_out : 1'b1;
  assign io_w = strobe_oe_out ? port_cycle_n_out : 1'b1;
  assign data_in = data_oe_out ? data_out : (ext_den ? ext_data : mem_data);
  cpubi_bus_if u_dut (.clk_in(clk_in), .rst_in(rst_in),
    .req_valid_in(req_valid_in), .req_ready_out(req_ready_out),
    .req_cyc_in(req_cyc_in), .req_addr_in(req_addr_in),
    .req_wdata_in(req_wdata_in), .resp_valid_out(resp_valid_out),
    .resp_rdata_out(resp_rdata_out), .tmr_sel_in(tmr_sel_in),
    .timer_output_in(timer_output_in), .addr_out(addr_out),
    .addr_oe_out(addr_oe_out), .addr_in(addr_in), .data_out(data_out),
    .data_oe_out(data_oe_out), .data_in(data_in), .rd_n_out(rd_n_out),
    .wr_n_out(wr_n_out), .memory_cycle_n_out(memory_cycle_n_out),
    .port_cycle_n_out(port_cycle_n_out), .strobe_oe_out(strobe_oe_out),
    .rd_n_in(rd_w), .wr_n_in(wr_w), .first_cycle_n_out(first_cycle_n_out),
    .dram_refresh_n_out(dram_refresh_n_out), .ctl_oe_out(ctl_oe_out),
    .bus_hold_request_n_in(bus_hold_request_n_in),
    .bus_hold_grant_n_out(bus_hold_grant_n_out), .wait_n_in(wait_n_in),
    .periph_rd_out(periph_rd_out), .periph_wr_out(periph_wr_out),
    .periph_addr_out(periph_addr_out), .periph_wdata_out(periph_wdata_out),
    .periph_rdata_in(periph_rdata_in));
  cpubi_mem_model u_mem (.clk_in(clk_in), .rst_in(rst_in), .slow_in(slow),
    .addr_in(addr_in), .mem_n_in(mem_w), .ioreq_n_in(io_w),
    .wr_n_in(wr_w), .data_out(mem_data), .wait_n_out(wait_n_in));
  // Clock generator
  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end
  // Compare and count
  task automatic check(input string what, input logic [23:0] seen,
                       input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Print the counts and the verdict, then stop
  task automatic final_report();
    $display("Checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // Issue one machine cycle and record what the pins showed
  task automatic run(input cpubi_pkg::cpubi_cyc_t k, input logic [19:0] a,
                     input logic [7:0] d);
    {s_mem, s_io, s_rd, s_wr, s_first, s_rf, s_both, s_doe} = 8'h00;
    @(posedge clk_in);
    req_valid_in <= 1'b1;
    req_cyc_in <= k;
    req_addr_in <= a;
    req_wdata_in <= d;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (req_ready_out !== 1'b1 && n < 20);
    @(posedge clk_in);
    req_valid_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
      s_mem |= !memory_cycle_n_out;
      s_io |= !port_cycle_n_out;
      s_rd |= !rd_n_out;
      s_wr |= !wr_n_out;
      s_both |= !memory_cycle_n_out && !port_cycle_n_out;
      s_first |= !first_cycle_n_out &&
                 !(memory_cycle_n_out && port_cycle_n_out);
      s_rf |= !dram_refresh_n_out && !memory_cycle_n_out;
      if (!memory_cycle_n_out || !port_cycle_n_out) seen_addr = addr_out;
      if (data_oe_out) seen_data = data_out;
      s_doe |= data_oe_out;
    end while (resp_valid_out !== 1'b1 && n < 40);
  endtask
  // Memory reads, prompt and stretched
  task automatic t_read();
    run(cpubi_pkg::CYC_MEM_RD, 20'hfedcb, 8'h00);
    check("latency", n, 4);
    check("mem strobe", s_mem, 1);
    check("rd strobe", s_rd, 1);
    check("port strobe", s_both | s_io, 0);
    check("address", seen_addr, 20'hfedcb);
    check("rdata", resp_rdata_out, 8'h6e);
    slow <= 1'b1;
    run(cpubi_pkg::CYC_MEM_RD, 20'h12345, 8'h00);
    slow <= 1'b0;
    check("stretched", n > 4, 1);
    check("slow rdata", resp_rdata_out, 8'he0);
    $display("Done read, mismatches %0d", failures);
  endtask
  // Writes, port read, fetches and acknowledge
  task automatic t_kinds();
    run(cpubi_pkg::CYC_IO_WR, 20'h00037, 8'h3c);
    check("io strobe", {s_io, s_wr, s_mem, s_rd}, 20'h0000c);
    check("port addr", seen_addr[7:0], 8'h37);
    check("wr data", seen_data, 8'h3c);
    run(cpubi_pkg::CYC_MEM_WR, 20'h80001, 8'hc3);
    check("mem wr", {s_mem, s_wr, s_io, s_both}, 20'h0000c);
    check("mem data", seen_data, 8'hc3);
    run(cpubi_pkg::CYC_IO_RD, 20'h000f0, 8'h00);
    check("io rd", {s_io, s_rd, s_mem}, 20'h00006);
    check("io rdata", resp_rdata_out, 8'h55);
    run(cpubi_pkg::CYC_FETCH, 20'h00100, 8'h00);
    check("fetch 1", {s_first, s_mem, s_io}, 20'h00006);
    run(cpubi_pkg::CYC_FETCH, 20'h00101, 8'h00);
    check("fetch 2", {s_first, s_mem, s_io}, 20'h00006);
    run(cpubi_pkg::CYC_INTACK, 20'h00000, 8'h00);
    check("intack", {s_first, s_io, s_mem, s_rd}, 20'h0000c);
    $display("Done kinds, mismatches %0d", failures);
  endtask
  // Two refreshes: counter address with refresh strobe
  task automatic t_refresh();
    for (int i = 0; i < 2; i++) begin
      run(cpubi_pkg::CYC_REFRESH, 20'hfffff, 8'h00);
      check("refresh strobe", s_rf, 1);
      check("refresh addr", seen_addr, 20'(i));
    end
    run(cpubi_pkg::CYC_PERIPH_WR, 20'h00040, 8'h96);
    check("periph data", {s_doe, seen_data}, 20'h00196);
    check("periph strobes", {s_mem, s_io, s_rd, s_wr}, 0);
    $display("Done refresh, mismatches %0d", failures);
  endtask
  // Bit 18 pin carries the timer output when selected
  task automatic t_timer();
    @(posedge clk_in);
    tmr_sel_in <= 1'b1;
    timer_output_in <= 1'b1;
    repeat (2) @(posedge clk_in);
    check("tmr on", {addr_out[18], addr_oe_out[18]}, 3);
    timer_output_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("tmr off", addr_out[18], 0);
    tmr_sel_in <= 1'b0;
    run(cpubi_pkg::CYC_MEM_RD, 20'h40000, 8'h00);
    check("bit 18", seen_addr, 20'h40000);
    $display("Done timer, mismatches %0d", failures);
  endtask
  // Hold, grant, external master read and write, release
  task automatic t_hold();
    bus_hold_request_n_in <= 1'b0;
    n = 0;
    do begin
      @(negedge clk_in);
      n++;
    end while (bus_hold_grant_n_out !== 1'b0 && n < 20);
    check("grant", bus_hold_grant_n_out, 0);
    check("floated", {addr_oe_out, data_oe_out, strobe_oe_out}, 0);
    periph_rdata_in <= 8'h71;
    ext_addr <= 20'h0005a;
    ext_rd_n <= 1'b0;
    {s_rd, s_doe} = 2'b00;
    repeat (8) begin
      @(negedge clk_in);
      s_rd |= periph_rd_out;
      if (data_oe_out) seen_data = data_out;
      s_doe |= data_oe_out;
    end
    check("ext rd", {s_rd, s_doe, seen_data}, 20'h00371);
    check("ext addr", periph_addr_out, 20'h0005a);
    @(posedge clk_in);
    ext_rd_n <= 1'b1;
    repeat (4) @(posedge clk_in);
    ext_den <= 1'b1;
    ext_data <= 8'he4;
    ext_wr_n <= 1'b0;
    s_wr = 1'b0;
    repeat (8) begin
      @(negedge clk_in);
      s_wr |= periph_wr_out;
    end
    check("ext wr", {s_wr, periph_wdata_out}, 20'h001e4);
    @(posedge clk_in);
    ext_wr_n <= 1'b1;
    ext_den <= 1'b0;
    bus_hold_request_n_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    check("released", {bus_hold_grant_n_out, strobe_oe_out}, 3);
    $display("Done hold, mismatches %0d", failures);
  endtask
  // Timeout guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      final_report();
    end
  end
  // Main sequence
  initial begin
    {failures, total_checks, cycles} = 0;
    {rst_in, bus_hold_request_n_in, ext_rd_n, ext_wr_n} = 4'hf;
    {req_valid_in, tmr_sel_in, timer_output_in, slow, ext_den} = 5'h00;
    req_cyc_in = cpubi_pkg::CYC_FETCH;
    {req_addr_in, ext_addr} = 40'h0;
    {req_wdata_in, periph_rdata_in, ext_data} = 24'h0;
    repeat (4) @(posedge clk_in);
    check("reset float", {addr_oe_out, data_oe_out, strobe_oe_out}, 0);
    check("reset grant", bus_hold_grant_n_out, 1);
    check("reset ctl", ctl_oe_out, 0);
    rst_in <= 1'b0;
    t_refresh();
    t_read();
    t_kinds();
    t_timer();
    t_hold();
    final_report();
  end
endmodule // testbench
